// *** frsp_pkg.sv ***
package frsp_pkg;

  // Row, panel and latch geometry of the program flash.
  localparam int unsigned ROW_WORDS = 32;
  localparam int unsigned ROW_BYTES = 96;
  localparam int unsigned PANEL_ROWS = 128;
  localparam int unsigned ARRAY_WORDS = PANEL_ROWS * ROW_WORDS;
  localparam int unsigned WORD_IDX_W = 12;
  localparam int unsigned ROW_IDX_W = 7;
  localparam int unsigned LATCH_IDX_W = 5;

  // Timing of one erase or program cycle.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned OP_TIME_NS = 2_000_000;
  localparam int unsigned OP_CYCLES_NOM = OP_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TBLWR_CYCLES = 2;

  // Control register fields and values.
  localparam int unsigned CTL_START_BIT = 15;
  localparam int unsigned CTL_WRITE_EN_BIT = 14;
  localparam int unsigned CTL_ERASE_BIT = 6;
  localparam int unsigned CTL_OP_LSB = 0;
  localparam logic [3:0] CTL_OP_ROW = 4'h1;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] ADDR_LOW_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [23:0] ERASED_WORD = 24'hFF_FFFF;

  // Register map of the core-side command port.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_EFF_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_BYTE_BIT = 3;
  localparam int unsigned CMD_SFR_LSB = 4;
  localparam int unsigned STAT_PEND_BIT = 0;
  localparam int unsigned STAT_STALL_BIT = 1;

  typedef enum logic [2:0] {
    OP_RD_LOW = 3'b000,
    OP_RD_HIGH = 3'b001,
    OP_WT_LOW = 3'b010,
    OP_WT_HIGH = 3'b011,
    OP_SFR_WR = 3'b100,
    OP_SFR_RD = 3'b101
  } frsp_op_type;

  typedef enum logic [2:0] {
    SFR_CONTROL = 3'b000,
    SFR_ADDR_LOW = 3'b001,
    SFR_ADDR_UP = 3'b010,
    SFR_KEY = 3'b011,
    SFR_PAGE = 3'b100
  } frsp_sfr_type;

  typedef enum logic [1:0] {
    KEY_NONE = 2'b00,
    KEY_ONE = 2'b01,
    KEY_BOTH = 2'b10
  } frsp_key_type;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WAIT = 2'b01,
    PH_ACK = 2'b10
  } frsp_phase_type;

endpackage

// *** frsp_link.sv ***
`timescale 1ns/1ps
`default_nettype none
interface frsp_link;
  import frsp_pkg::*;
  logic req;
  frsp_op_type op;
  frsp_sfr_type sfr;
  logic byte_mode;
  logic [15:0] effective_address;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  logic stall;

  modport device (input req, input op, input sfr, input byte_mode, input effective_address, input wdata,
                  output ack, output rdata, output stall);
  modport core (output req, output op, output sfr, output byte_mode, output effective_address, output wdata,
                input ack, input rdata, input stall);
endinterface
`default_nettype wire

// *** frsp_device.sv ***
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module frsp_device
  import frsp_pkg::*;
#(
  parameter int unsigned OP_CYCLES = OP_CYCLES_NOM
)
(
  input wire logic CLK_I,
  input wire logic RST_I,
  frsp_link.device LINK,
  output logic STALL_O,
  output logic OP_DONE_O
);

  logic [23:0] mem [ARRAY_WORDS];
  logic [23:0] latch [ROW_WORDS];
  logic [15:0] ctl;
  logic [15:0] addr_low;
  logic [7:0] addr_up;
  logic [7:0] page;
  logic [15:0] rdata;
  logic [17:0] cnt;
  logic done;
  frsp_key_type key_st;
  frsp_key_type next_key_st;
  frsp_phase_type phase;

  function automatic logic [WORD_IDX_W-1:0] word_index(input logic [23:0] addr);
    word_index = addr[WORD_IDX_W:1];
  endfunction

  function automatic logic [15:0] table_read(input logic [23:0] w, input logic high,
                                             input logic bmode, input logic odd);
    logic [15:0] r;
    r = 16'h0000;
    if (!high)
    begin
      if (bmode)
        r = odd ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
      else
        r = w[15:0];
    end
    else if (!(bmode && odd))
    begin
      r = {8'h00, w[23:16]};
    end
    table_read = r;
  endfunction

  wire take = LINK.req && (phase == PH_IDLE) && !ctl[CTL_START_BIT];
  wire [23:0] full_addr = {page, LINK.effective_address};
  wire [23:0] row_addr = {addr_up, addr_low};
  wire [WORD_IDX_W-1:0] row_word = word_index(row_addr);
  wire [ROW_IDX_W-1:0] row_sel = row_word[WORD_IDX_W-1:LATCH_IDX_W];
  wire [LATCH_IDX_W-1:0] latch_idx = LINK.effective_address[LATCH_IDX_W:1];
  wire [23:0] rd_word = mem[word_index(full_addr)];
  wire is_table = (LINK.op == OP_RD_LOW) || (LINK.op == OP_RD_HIGH) ||
                  (LINK.op == OP_WT_LOW) || (LINK.op == OP_WT_HIGH);
  wire is_tblwr = (LINK.op == OP_WT_LOW) || (LINK.op == OP_WT_HIGH);
  wire sfr_wr = take && (LINK.op == OP_SFR_WR);
  wire key_wr = sfr_wr && (LINK.sfr == SFR_KEY);
  wire ctl_wr = sfr_wr && (LINK.sfr == SFR_CONTROL);
  wire row_mode = LINK.wdata[CTL_OP_LSB +: 4] == CTL_OP_ROW;
  wire start_ok = ctl_wr && LINK.wdata[CTL_START_BIT] && LINK.wdata[CTL_WRITE_EN_BIT] &&
                  row_mode && (key_st == KEY_BOTH);
  wire op_end = ctl[CTL_START_BIT] && (cnt == 18'(OP_CYCLES - 1));
  wire row_step = ctl[CTL_START_BIT] && (cnt < 18'(ROW_WORDS));
  wire [LATCH_IDX_W-1:0] step_idx = cnt[LATCH_IDX_W-1:0];
  wire [15:0] tbl_rdata = table_read(rd_word, LINK.op == OP_RD_HIGH, LINK.byte_mode, LINK.effective_address[0]);
  wire [15:0] sfr_rdata = (LINK.sfr == SFR_CONTROL) ? ctl :
                          (LINK.sfr == SFR_ADDR_LOW) ? addr_low :
                          (LINK.sfr == SFR_ADDR_UP) ? {8'h00, addr_up} :
                          (LINK.sfr == SFR_PAGE) ? {8'h00, page} : 16'h0000;

  // Any accepted request other than a key write breaks the unlock pair.
  always_comb
  begin
    next_key_st = key_st;
    if (key_wr)
    begin
      if (LINK.wdata[7:0] == KEY_FIRST)
        next_key_st = KEY_ONE;
      else if ((LINK.wdata[7:0] == KEY_SECOND) && (key_st == KEY_ONE))
        next_key_st = KEY_BOTH;
      else
        next_key_st = KEY_NONE;
    end
    else if (take)
    begin
      next_key_st = KEY_NONE;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      phase <= PH_IDLE;
      rdata <= 16'h0000;
      key_st <= KEY_NONE;
    end
    else
    begin
      key_st <= next_key_st;
      case (phase)
        PH_IDLE:
        begin
          if (take)
          begin
            phase <= is_tblwr ? PH_WAIT : PH_ACK;
            rdata <= is_table ? tbl_rdata : sfr_rdata;
          end
        end
        PH_WAIT:
          phase <= PH_ACK;
        default:
          phase <= PH_IDLE;
      endcase
    end
  end

  // Control register: software writes everything but the start bit, which only a keyed write sets.
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ctl <= CTL_RESET;
      cnt <= '0;
      done <= 1'b0;
    end
    else
    begin
      done <= op_end;
      if (op_end)
      begin
        ctl[CTL_START_BIT] <= 1'b0;
        cnt <= '0;
      end
      else if (ctl[CTL_START_BIT])
      begin
        cnt <= cnt + 18'd1;
      end
      else if (ctl_wr)
      begin
        ctl <= {start_ok, LINK.wdata[14:0]};
      end
    end
  end

  // Address and page registers; frozen while the core is stalled since no request is taken.
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      addr_low <= ADDR_LOW_RESET;
      addr_up <= BYTE_RESET;
      page <= BYTE_RESET;
    end
    else if (take && is_table)
    begin
      addr_low <= LINK.effective_address;
      addr_up <= page;
    end
    else if (sfr_wr)
    begin
      if (LINK.sfr == SFR_ADDR_LOW)
        addr_low <= LINK.wdata;
      else if (LINK.sfr == SFR_ADDR_UP)
        addr_up <= LINK.wdata[7:0];
      else if (LINK.sfr == SFR_PAGE)
        page <= LINK.wdata[7:0];
    end
  end

  // Table writes touch the latches and the address registers, never the array; the array changes solely during a keyed cycle.
  always_ff @(posedge CLK_I)
  begin
    if (take && (LINK.op == OP_WT_LOW))
    begin
      if (!LINK.byte_mode)
        latch[latch_idx][15:0] <= LINK.wdata;
      else if (LINK.effective_address[0])
        latch[latch_idx][15:8] <= LINK.wdata[7:0];
      else
        latch[latch_idx][7:0] <= LINK.wdata[7:0];
    end
    else if (take && (LINK.op == OP_WT_HIGH) && !(LINK.byte_mode && LINK.effective_address[0]))
    begin
      latch[latch_idx][23:16] <= LINK.wdata[7:0];
    end
  end

  // The row is written one word per cycle in the first 32 cycles; the rest is cell timing.
  always_ff @(posedge CLK_I)
  begin
    if (row_step)
    begin
      if (ctl[CTL_ERASE_BIT])
        mem[{row_sel, step_idx}] <= ERASED_WORD;
      else
        mem[{row_sel, step_idx}] <= latch[step_idx];
    end
  end

  assign LINK.ack = (phase == PH_ACK);
  assign LINK.rdata = rdata;
  assign LINK.stall = ctl[CTL_START_BIT];
  assign STALL_O = ctl[CTL_START_BIT];
  assign OP_DONE_O = done;

endmodule
`default_nettype wire

// *** frsp_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module frsp_core
  import frsp_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic [31:0] HRDATA_O,
  frsp_link.core LINK
);

  logic pend;
  frsp_op_type cmd_op;
  frsp_sfr_type cmd_sfr;
  logic cmd_byte;
  logic [15:0] effective_address;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [31:0] hrdata;
  logic wr_phase;
  logic [7:0] wr_addr;

  wire addr_ok = HSEL_I && HTRANS_I[1] && HREADY_I;
  wire [7:0] offs = HADDR_I[7:0];
  wire known = (HADDR_I[31:8] == 24'h00_0000);
  wire [31:0] rd_mux = !known ? 32'h0000_0000 :
                       (offs == REG_CMD) ? {25'h0, cmd_sfr, cmd_byte, cmd_op} :
                       (offs == REG_EFF_ADDR) ? {16'h0000, effective_address} :
                       (offs == REG_WDATA) ? {16'h0000, wdata} :
                       (offs == REG_RDATA) ? {16'h0000, rdata} :
                       (offs == REG_STATUS) ? {30'h0, LINK.stall, pend} : 32'h0000_0000;
  wire cmd_wr = wr_phase && (wr_addr == REG_CMD) && !pend;

  // The size field is not checked: only whole-word transfers are used on this port.
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      wr_phase <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wr_phase <= addr_ok && HWRITE_I && known;
      wr_addr <= offs;
      if (addr_ok && !HWRITE_I)
        hrdata <= rd_mux;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      effective_address <= 16'h0000;
      wdata <= 16'h0000;
    end
    else if (wr_phase && !pend)
    begin
      if (wr_addr == REG_EFF_ADDR)
        effective_address <= HWDATA_I[15:0];
      else if (wr_addr == REG_WDATA)
        wdata <= HWDATA_I[15:0];
    end
  end

  // A command written while one is still outstanding is dropped; software polls the status word.
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      pend <= 1'b0;
      cmd_op <= OP_SFR_RD;
      cmd_sfr <= SFR_CONTROL;
      cmd_byte <= 1'b0;
      rdata <= 16'h0000;
    end
    else if (pend)
    begin
      if (LINK.ack)
      begin
        pend <= 1'b0;
        rdata <= LINK.rdata;
      end
    end
    else if (cmd_wr)
    begin
      pend <= 1'b1;
      cmd_op <= frsp_op_type'(HWDATA_I[CMD_OP_LSB +: 3]);
      cmd_byte <= HWDATA_I[CMD_BYTE_BIT];
      cmd_sfr <= frsp_sfr_type'(HWDATA_I[CMD_SFR_LSB +: 3]);
    end
  end

  assign LINK.req = pend;
  assign LINK.op = cmd_op;
  assign LINK.sfr = cmd_sfr;
  assign LINK.byte_mode = cmd_byte;
  assign LINK.effective_address = effective_address;
  assign LINK.wdata = wdata;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = hrdata;

endmodule
`default_nettype wire

// *** frsp_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module frsp_assertions
  import frsp_pkg::*;
#(
  parameter int unsigned OP_CYCLES = OP_CYCLES_NOM
)
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic req,
  input wire frsp_op_type op,
  input wire frsp_sfr_type sfr,
  input wire logic byte_mode,
  input wire logic [15:0] effective_address,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata,
  input wire logic stall
);
  logic [31:0] cnt;
  logic [8:0] k1;
  logic [8:0] k2;
  wire logic is_key;
  // Only answered requests shift in, so any other request voids the key pair.
  assign is_key = op == OP_SFR_WR && sfr == SFR_KEY;
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      cnt <= '0;
      k1 <= '0;
      k2 <= '0;
    end
    else
    begin
      cnt <= stall ? cnt + 32'h0000_0001 : '0;
      if (ack)
      begin
        k1 <= {is_key, wdata[7:0]};
        k2 <= k1;
      end
    end
  end
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  sequence s_wt;
    $rose(req) && !stall && (op == OP_WT_LOW || op == OP_WT_HIGH);
  endsequence
  sequence s_ans;
    !ack ##1 !ack ##1 ack;
  endsequence
  property p_wt;
    s_wt |-> s_ans;
  endproperty
  property p_rd;
    $rose(req) && !stall && (op == OP_RD_LOW || op == OP_RD_HIGH) |=> ack;
  endproperty
  property p_ack;
    ack |=> !ack && !req;
  endproperty
  property p_hold;
    req && !ack |=> req && $stable(op) && $stable(effective_address) && $stable(wdata);
  endproperty
  property p_quiet;
    stall && $past(stall) |-> !ack && $stable(rdata);
  endproperty
  property p_len;
    $fell(stall) |-> cnt == OP_CYCLES;
  endproperty
  property p_ctl;
    $rose(stall) |-> $past(req) && $past(op) == OP_SFR_WR && $past(sfr) == SFR_CONTROL
      && ($past(wdata) & 16'hC00F) == {2'b11, 10'h000, CTL_OP_ROW};
  endproperty
  property p_key;
    $rose(stall) |-> k2 == {1'b1, KEY_FIRST} && k1 == {1'b1, KEY_SECOND};
  endproperty
  a_wt: assert property (p_wt) else $error("table write ack timing");
  a_rd: assert property (p_rd) else $error("table read ack timing");
  a_ack: assert property (p_ack) else $error("ack not single");
  a_hold: assert property (p_hold) else $error("request moved");
  a_quiet: assert property (p_quiet) else $error("taken while stalled");
  a_len: assert property (p_len) else $error("stall length");
  a_ctl: assert property (p_ctl) else $error("start without control");
  a_key: assert property (p_key) else $error("start without key");
endmodule
`default_nettype wire

// *** test_flash_row_self_programming.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_flash_row_self_programming
  import frsp_pkg::*;
;
  localparam int unsigned OPC = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic hready;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic stall_o;
  wire logic done;
  int num_errors = 0;
  int comparisons = 0;
  frsp_link link ();
  frsp_core frsp_core_i (.CLK_I(clk), .RST_I(rst), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hready), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .HRDATA_O(hrdata), .LINK(link.core));
  frsp_device #(.OP_CYCLES(OPC)) frsp_device_i (.CLK_I(clk), .RST_I(rst), .LINK(link.device),
    .STALL_O(stall_o), .OP_DONE_O(done));
  frsp_assertions #(.OP_CYCLES(OPC)) frsp_assertions_i (.CLK_I(clk), .RST_I(rst), .req(link.req),
    .op(link.op), .sfr(link.sfr), .byte_mode(link.byte_mode), .effective_address(link.effective_address),
    .wdata(link.wdata),
    .ack(link.ack), .rdata(link.rdata), .stall(link.stall));
  always #5 clk = ~clk;
  task end_sim;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask
  task cmd(input frsp_op_type o, input frsp_sfr_type s, input logic b, input logic [15:0] e,
    input logic [15:0] d, output logic [31:0] q);
    logic [31:0] t;
    ahb(1'b1, REG_EFF_ADDR, {16'h0000, e}, t);
    ahb(1'b1, REG_WDATA, {16'h0000, d}, t);
    ahb(1'b1, REG_CMD, {25'h000_0000, s, b, o}, t);
    t = 32'h0000_0001;
    while (t[STAT_PEND_BIT] !== 1'b0) ahb(1'b0, REG_STATUS, 32'h0000_0000, t);
    ahb(1'b0, REG_RDATA, 32'h0000_0000, q);
  endtask
  task wsfr(input frsp_sfr_type s, input logic [15:0] d);
    logic [31:0] q;
    cmd(OP_SFR_WR, s, 1'b0, 16'h0000, d, q);
  endtask
  task rd(input frsp_op_type o, input frsp_sfr_type s, input logic b, input logic [15:0] e, input logic [15:0] x);
    logic [31:0] q;
    cmd(o, s, b, e, 16'h0000, q);
    chk(q, {16'h0000, x});
  endtask
  task go(input logic [15:0] ctl);
    logic [31:0] q;
    int n;
    wsfr(SFR_KEY, {8'h00, KEY_FIRST});
    wsfr(SFR_KEY, {8'h00, KEY_SECOND});
    wsfr(SFR_CONTROL, ctl);
    ahb(1'b0, REG_STATUS, 32'h0000_0000, q);
    chk(q, 32'h0000_0002);
    n = 0;
    while (done !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0000_0000, done}, 32'h0000_0001);
    chk({31'h0000_0000, stall_o}, 32'h0000_0000);
    rd(OP_SFR_RD, SFR_CONTROL, 1'b0, 16'h0000, ctl & 16'h7FFF);
  endtask
  task bad_key(input logic [7:0] a, input logic [7:0] b, input logic mid, input logic [15:0] ctl);
    logic [31:0] q;
    wsfr(SFR_KEY, {8'h00, a});
    wsfr(SFR_KEY, {8'h00, b});
    if (mid)
      cmd(OP_SFR_RD, SFR_PAGE, 1'b0, 16'h0000, 16'h0000, q);
    wsfr(SFR_CONTROL, ctl);
    chk({31'h0000_0000, stall_o}, 32'h0000_0000);
  endtask
  task t_regs;
    rd(OP_SFR_RD, SFR_CONTROL, 1'b0, 16'h0000, CTL_RESET);
    rd(OP_SFR_RD, SFR_ADDR_LOW, 1'b0, 16'h0000, ADDR_LOW_RESET);
    wsfr(SFR_ADDR_UP, 16'h0012);
    rd(OP_SFR_RD, SFR_ADDR_UP, 1'b0, 16'h0000, 16'h0012);
    wsfr(SFR_KEY, 16'h0055);
    rd(OP_SFR_RD, SFR_KEY, 1'b0, 16'h0000, 16'h0000);
  endtask
  task t_prog;
    logic [31:0] q;
    wsfr(SFR_PAGE, 16'h0001);
    wsfr(SFR_ADDR_UP, 16'h0001);
    go(16'hC041);
    rd(OP_RD_LOW, SFR_CONTROL, 1'b0, 16'h0000, 16'hFFFF);
    rd(OP_RD_HIGH, SFR_CONTROL, 1'b0, 16'h003E, 16'h00FF);
    wsfr(SFR_ADDR_UP, 16'h0012);
    // Latches are filled in ascending order from an aligned row start.
    for (int i = 0; i < 32; i++)
    begin
      cmd(OP_WT_LOW, SFR_CONTROL, 1'b0, 16'(2 * i), 16'hA500 + 16'(i), q);
      cmd(OP_WT_HIGH, SFR_CONTROL, 1'b0, 16'(2 * i), 16'(i), q);
    end
    rd(OP_SFR_RD, SFR_ADDR_LOW, 1'b0, 16'h0000, 16'h003E);
    rd(OP_SFR_RD, SFR_ADDR_UP, 1'b0, 16'h0000, 16'h0001);
    rd(OP_RD_LOW, SFR_CONTROL, 1'b0, 16'h0000, 16'hFFFF);
    go(16'hC001);
    rd(OP_RD_LOW, SFR_CONTROL, 1'b0, 16'h0000, 16'hA500);
    rd(OP_RD_HIGH, SFR_CONTROL, 1'b0, 16'h003E, 16'h001F);
    rd(OP_RD_LOW, SFR_CONTROL, 1'b1, 16'h0003, 16'h00A5);
    rd(OP_RD_HIGH, SFR_CONTROL, 1'b1, 16'h0002, 16'h0001);
    rd(OP_RD_HIGH, SFR_CONTROL, 1'b1, 16'h0003, 16'h0000);
    wsfr(SFR_ADDR_LOW, 16'h0040);
    go(16'hC041);
    rd(OP_RD_LOW, SFR_CONTROL, 1'b0, 16'h0000, 16'hA500);
    rd(OP_RD_LOW, SFR_CONTROL, 1'b0, 16'h0040, 16'hFFFF);
  endtask
  task t_key;
    bad_key(KEY_FIRST, KEY_SECOND, 1'b1, 16'hC041);
    bad_key(KEY_FIRST, KEY_SECOND, 1'b0, 16'h8041);
    bad_key(KEY_SECOND, KEY_FIRST, 1'b0, 16'hC041);
    rd(OP_SFR_RD, SFR_CONTROL, 1'b0, 16'h0000, 16'h4041);
    rd(OP_RD_LOW, SFR_CONTROL, 1'b0, 16'h0000, 16'hA500);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_prog();
    t_key();
    end_sim();
  end
  initial
  begin
    #(500_000);
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
